/* logic/light_prox_defines.svh */
// register command codes, field positions, reset values and timing counts
`ifndef LIGHT_PROX_DEFINES_SVH
`define LIGHT_PROX_DEFINES_SVH
`define CMD_AMB_CONF 8'h00
`define CMD_AMB_THH 8'h01
`define CMD_AMB_THL 8'h02
`define CMD_PROX_CONF12 8'h03
`define CMD_PROX_CONF34 8'h04
`define CMD_PROX_CANC 8'h05
`define CMD_PROX_THL 8'h06
`define CMD_PROX_THH 8'h07
`define CMD_PROX_DATA 8'h08
`define CMD_AMB_DATA 8'h0B
`define CMD_FLAGS 8'h0D
`define CMD_IDENT 8'h0E
`define AMB_IT_MSB 7
`define AMB_IT_LSB 5
`define AMB_HD_BIT 11
`define AMB_NS_BIT 12
`define AMB_PERS_MSB 3
`define AMB_PERS_LSB 2
`define AMB_IRQ_EN_BIT 1
`define AMB_SHUTDOWN_BIT 0
`define PROX_DUTY_MSB 7
`define PROX_DUTY_LSB 6
`define PROX_PERS_MSB 5
`define PROX_PERS_LSB 4
`define PROX_SD_BIT 0
`define PROX_IRQ_MSB 9
`define PROX_IRQ_LSB 8
`define PROX_MECH_BIT 3
`define PROX_FORCE_BIT 3
`define PROX_TRIG_BIT 2
`define PROX_LOGIC_BIT 14
`define FLAG_AMB_LOW 13
`define FLAG_AMB_HIGH 12
`define FLAG_SUN 10
`define FLAG_CLOSE 9
`define FLAG_AWAY 8
`define RST_AMB_CONF 16'h0001
`define RST_PROX_CONF12 16'h0001
`define RST_ZERO 16'h0000
`define CLK_MHZ 50
`define AMB_BASE_MS 50
`define AMB_BASE_CYC (`AMB_BASE_MS * `CLK_MHZ * 1000)
`define PROX_PERIOD_US 5000
`define PROX_PERIOD_CYC (`PROX_PERIOD_US * `CLK_MHZ)
`define EMIT_ON_CYC 32
`endif

/* logic/light_prox_pkg.sv */
// types shared by the sensor readout logic
package light_prox_pkg;
  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
  } window_t;
  typedef struct packed {
    logic above;
    logic below;
  } cross_t;
endpackage

/* logic/persist_counter.sv */
// consecutive-period persistence counter for one sensor
`timescale 1ns/100ps
module persist_counter #(
  parameter int CW = 4
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic sample,
  input wire logic outside,
  input wire logic [CW-1:0] need,
  output logic hit
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  wire logic reached = (cnt_q + 1'b1) >= need;
  assign hit = sample && outside && reached;
  // restart when back inside before count reached
  assign cnt_d = !outside ? '0 : (reached ? cnt_q : cnt_q + 1'b1); // [RULE19]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (sample) begin
      cnt_q <= cnt_d;
    end
  end
endmodule // persist_counter

/* logic/light_prox_core.sv */
// ambient light and proximity result, threshold and interrupt logic
//
// What this block does
// [RULE1] emitter pulsed at programmable on/off duty ratio
// [RULE2] registers hold defaults after reset, no init
// [RULE3] ambient interrupt on high or low crossing
// [RULE4] integration time field selects 50-800 ms
// [RULE5] each range option halves sensitivity, doubles range
// [RULE6] ambient persistence 1, 2, 4 or 8 periods
// [RULE7] proximity persistence 1 to 4 periods
// [RULE8] separate high and low proximity thresholds
// [RULE9] single-shot mode: one measurement per trigger
// [RULE10] cancellation value subtracted from raw proximity
// [RULE11] every command register is readable
// [RULE12] ambient result low byte then high byte
// [RULE13] both sources share one active-low interrupt pin
// [RULE14] registers stay accessible while interrupt asserted
// [RULE15] host should set detection mechanism bit
// [RULE16] flag rise pulls pin low, read clears
// [RULE17] flag byte layout in high half of 0x0D
// [RULE18] logic output mode: pin follows close state
// [RULE19] persistence restarts when back inside window
// [RULE20] cancellation subtraction saturates at zero
`timescale 1ns/100ps
`include "light_prox_defines.svh"
module light_prox_core #(
  parameter int AMB_BASE_CYC = `AMB_BASE_CYC,
  parameter int PROX_PERIOD_CYC = `PROX_PERIOD_CYC,
  parameter logic [15:0] IDENT_CODE = 16'h0055 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_cmd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] amb_raw,
  input wire logic [15:0] prox_raw,
  input wire logic sunlight,
  output logic emitter_drive_pin,
  output logic amb_sample,
  output logic prox_sample,
  input wire logic int_n_in,
  output logic int_n_out,
  output logic int_n_oe
);
  // refuse periods the 32-bit counters cannot hold after the 16x shift
  if (AMB_BASE_CYC < 1 || AMB_BASE_CYC > 32'h0FFFFFFF || PROX_PERIOD_CYC < 64) begin : g_bad_param
    $error("period parameters out of range");
  end
  // ==========================================================
  // registers
  logic [15:0] amb_conf_q, amb_thh_q, amb_thl_q, conf12_q, conf34_q;
  logic [15:0] canc_q, prox_thl_q, prox_thh_q, amb_data_q, prox_data_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic trig_pend_q;
  logic int_q;
  logic close_q;
  light_prox_pkg::window_t amb_win, prox_win;
  assign amb_win = '{high: amb_thh_q, low: amb_thl_q};
  assign prox_win = '{high: prox_thh_q, low: prox_thl_q}; // [RULE8]
  function automatic logic wr_to(input logic [7:0] c);
    return reg_wr && (reg_cmd == c);
  endfunction
  always_ff @(posedge sys_clk) begin
    if (srst) begin // [RULE2]
      amb_conf_q <= `RST_AMB_CONF;
      amb_thh_q <= `RST_ZERO;
      amb_thl_q <= `RST_ZERO;
      conf12_q <= `RST_PROX_CONF12;
      conf34_q <= `RST_ZERO;
      canc_q <= `RST_ZERO;
      prox_thl_q <= `RST_ZERO;
      prox_thh_q <= `RST_ZERO;
    end else begin // [RULE14]
      if (wr_to(`CMD_AMB_CONF)) amb_conf_q <= reg_wdata;
      if (wr_to(`CMD_AMB_THH)) amb_thh_q <= reg_wdata;
      if (wr_to(`CMD_AMB_THL)) amb_thl_q <= reg_wdata;
      if (wr_to(`CMD_PROX_CONF12)) conf12_q <= reg_wdata;
      // trigger bit is never stored; it always reads back as zero
      if (wr_to(`CMD_PROX_CONF34)) begin
        conf34_q <= reg_wdata & ~(16'h0001 << `PROX_TRIG_BIT);
      end
      if (wr_to(`CMD_PROX_CANC)) canc_q <= reg_wdata;
      if (wr_to(`CMD_PROX_THL)) prox_thl_q <= reg_wdata;
      if (wr_to(`CMD_PROX_THH)) prox_thh_q <= reg_wdata;
    end
  end
  // ==========================================================
  // ambient timing
  wire logic [2:0] it_sel = amb_conf_q[`AMB_IT_MSB:`AMB_IT_LSB];
  wire logic [2:0] it_shift = it_sel[2] ? 3'h4 : it_sel; // [RULE4]
  wire logic amb_on = !amb_conf_q[`AMB_SHUTDOWN_BIT];
  logic [31:0] amb_cnt_q;
  wire logic [31:0] amb_len = 32'(AMB_BASE_CYC) << it_shift; // [RULE4]
  assign amb_sample = amb_on && (amb_cnt_q >= amb_len - 32'h1);
  always_ff @(posedge sys_clk) begin
    if (srst || !amb_on || amb_sample) begin
      amb_cnt_q <= 32'h0;
    end else begin
      amb_cnt_q <= amb_cnt_q + 32'h1;
    end
  end
  // each option divides the count by two
  wire logic [1:0] amb_div = 2'(amb_conf_q[`AMB_HD_BIT]) + 2'(amb_conf_q[`AMB_NS_BIT]);
  wire logic [15:0] amb_scaled = amb_raw >> amb_div; // [RULE5]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      amb_data_q <= 16'h0000;
    end else if (amb_sample) begin
      amb_data_q <= amb_scaled;
    end
  end
  light_prox_pkg::cross_t amb_x;
  assign amb_x.above = amb_scaled > amb_win.high; // [RULE3]
  assign amb_x.below = amb_scaled < amb_win.low;
  wire logic [1:0] amb_pers = amb_conf_q[`AMB_PERS_MSB:`AMB_PERS_LSB];
  wire logic [3:0] amb_need = 4'h1 << amb_pers; // [RULE6]
  logic amb_hit;
  persist_counter #(.CW(4)) u_amb_pers (
    .sys_clk(sys_clk),
    .srst(srst),
    .sample(amb_sample),
    .outside(amb_x.above || amb_x.below),
    .need(amb_need),
    .hit(amb_hit)
  );
  wire logic amb_irq_en = amb_conf_q[`AMB_IRQ_EN_BIT];
  // ==========================================================
  // proximity timing and emitter
  wire logic force_mode = conf34_q[`PROX_FORCE_BIT];
  wire logic prox_on = !conf12_q[`PROX_SD_BIT];
  wire logic trig_wr = wr_to(`CMD_PROX_CONF34) && reg_wdata[`PROX_TRIG_BIT];
  logic [31:0] prox_cnt_q;
  wire logic [31:0] prox_cnt_d = prox_cnt_q + 32'h1;
  // duty 1/40,1/80,1/160,1/320 sets the period
  wire logic [31:0] prox_len = 32'(`EMIT_ON_CYC * 40) << conf12_q[`PROX_DUTY_MSB:`PROX_DUTY_LSB];
  wire logic free_tick = prox_cnt_q >= prox_len - 32'h1;
  assign prox_sample = prox_on && (force_mode ? (trig_pend_q && free_tick) : free_tick); // [RULE9]
  wire logic running = prox_on && (!force_mode || trig_pend_q);
  assign emitter_drive_pin = running && (prox_cnt_q < 32'(`EMIT_ON_CYC)); // [RULE1]
  always_ff @(posedge sys_clk) begin
    if (srst || !running || free_tick) begin
      prox_cnt_q <= 32'h0;
    end else begin
      prox_cnt_q <= prox_cnt_d;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trig_pend_q <= 1'b0;
    end else if (trig_wr && force_mode) begin
      trig_pend_q <= 1'b1; // [RULE9]
    end else if (prox_sample) begin
      trig_pend_q <= 1'b0;
    end
  end
  wire logic [15:0] prox_sub = (prox_raw > canc_q) ? prox_raw - canc_q : 16'h0000; // [RULE20]
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prox_data_q <= 16'h0000;
    end else if (prox_sample) begin
      prox_data_q <= prox_sub; // [RULE10]
    end
  end
  wire logic prox_above = prox_sub > prox_win.high;
  wire logic prox_below = prox_sub < prox_win.low;
  wire logic [2:0] prox_need = 3'(conf12_q[`PROX_PERS_MSB:`PROX_PERS_LSB]) + 3'h1; // [RULE7]
  logic prox_hit;
  persist_counter #(.CW(3)) u_prox_pers (
    .sys_clk(sys_clk),
    .srst(srst),
    .sample(prox_sample),
    .outside(prox_above),
    .need(prox_need),
    .hit(prox_hit)
  );
  wire logic [1:0] prox_irq = conf12_q[`PROX_IRQ_MSB:`PROX_IRQ_LSB];
  // mechanism bit: away only after a close; otherwise any low crossing
  wire logic mech = conf12_q[`PROX_MECH_BIT]; // [RULE15]
  wire logic close_ev = prox_hit && !close_q;
  wire logic away_ev = prox_sample && prox_below && (close_q || !mech);
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      close_q <= 1'b0;
    end else if (close_ev) begin
      close_q <= 1'b1;
    end else if (away_ev) begin
      close_q <= 1'b0;
    end
  end
  // ==========================================================
  // flags and interrupt pin
  logic [7:0] set_v;
  assign set_v = {2'b00,
                  amb_hit && amb_x.below && amb_irq_en,
                  amb_hit && amb_x.above && amb_irq_en,
                  1'b0,
                  sunlight,
                  close_ev && prox_irq[0],
                  away_ev && prox_irq[1]}; // [RULE17]
  wire logic flag_rd = reg_rd && (reg_cmd == `CMD_FLAGS);
  // a new event wins over the read clear
  assign flags_d = (flag_rd ? 8'h00 : flags_q) | set_v; // [RULE16]
  wire logic logic_mode = conf34_q[`PROX_LOGIC_BIT];
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flags_q <= 8'h00;
      int_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      int_q <= logic_mode ? close_q : (flags_d != 8'h00); // [RULE13] [RULE18]
    end
  end
  assign int_n_out = 1'b0;
  assign int_n_oe = int_q; // [RULE13]
  // ==========================================================
  // read mux
  always_comb begin // [RULE11]
    unique case (reg_cmd)
      `CMD_AMB_CONF: reg_rdata = amb_conf_q;
      `CMD_AMB_THH: reg_rdata = amb_thh_q;
      `CMD_AMB_THL: reg_rdata = amb_thl_q;
      `CMD_PROX_CONF12: reg_rdata = conf12_q;
      `CMD_PROX_CONF34: reg_rdata = conf34_q;
      `CMD_PROX_CANC: reg_rdata = canc_q;
      `CMD_PROX_THL: reg_rdata = prox_thl_q;
      `CMD_PROX_THH: reg_rdata = prox_thh_q;
      `CMD_PROX_DATA: reg_rdata = prox_data_q;
      `CMD_AMB_DATA: reg_rdata = amb_data_q; // [RULE12]
      `CMD_FLAGS: reg_rdata = {flags_q, 8'h00};
      `CMD_IDENT: reg_rdata = IDENT_CODE;
      default: reg_rdata = 16'h0000;
    endcase
  end
  wire logic unused_ok = int_n_in;
endmodule // light_prox_core

/* verif/light_prox_props.sv */
// port assertions for the sensor readout block
`timescale 1ns/100ps
`include "light_prox_defines.svh"
module light_prox_props (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_cmd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic sunlight,
  input wire logic emitter_drive_pin,
  input wire logic amb_sample,
  input wire logic prox_sample,
  input wire logic int_n_out,
  input wire logic int_n_oe
);
  logic [3:0] ev_q;
  logic [5:0] on_q;
  logic mode_q;
  wire ev = amb_sample | prox_sample | sunlight;
  wire frd = reg_rd && reg_cmd == `CMD_FLAGS;
  wire w34 = reg_wr && reg_cmd == `CMD_PROX_CONF34;
  always_ff @(posedge sys_clk) begin
    ev_q <= srst ? 4'h0 : {ev_q[2:0], ev};
    on_q <= (srst || !emitter_drive_pin) ? 6'h00 : on_q + 6'h01;
    mode_q <= srst ? 1'b0 : w34 ? reg_wdata[`PROX_LOGIC_BIT] : mode_q;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  oe_reset_a: assert property (disable iff (1'b0) srst |=> !int_n_oe && !emitter_drive_pin)
    else $error("outputs active after reset");
  pin_drive_a: assert property (int_n_oe |-> !int_n_out)
    else $error("pin enabled but not driven low");
  clear_read_a: assert property (frd && !mode_q && !ev && ev_q == 4'h0 |=> !int_n_oe)
    else $error("flag read did not release pin");
  oe_cause_a: assert property ($rose(int_n_oe) |-> ev || ev_q != 4'h0)
    else $error("pin pulled without sample event");
  oe_hold_a: assert property (int_n_oe && !mode_q && !frd && !w34 |=> int_n_oe)
    else $error("pin released without flag read");
  emit_width_a: assert property ($fell(emitter_drive_pin) && !$past(srst) |-> on_q == 6'h20)
    else $error("emitter on time wrong");
  unmapped_zero_a: assert property (reg_cmd inside {8'h09, 8'h0A, 8'h0C} |-> reg_rdata == 16'h0000)
    else $error("unmapped command reads nonzero");
  flag_layout_a: assert property (reg_cmd == `CMD_FLAGS |-> (reg_rdata & 16'hC8FF) == 16'h0000)
    else $error("reserved flag bits set");
  cover property (frd && int_n_oe);
  cover property ($fell(emitter_drive_pin));
  cover property (prox_sample);
endmodule // light_prox_props
bind light_prox_core light_prox_props u_props (.sys_clk(sys_clk), .srst(srst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .sunlight(sunlight), .emitter_drive_pin(emitter_drive_pin), .amb_sample(amb_sample),
  .prox_sample(prox_sample), .int_n_out(int_n_out), .int_n_oe(int_n_oe));

/* verif/host_bus_model.sv */
// host model: register strobes, read capture, pulled-up irq line
`timescale 1ns/100ps
module host_bus_model (
  input wire logic sys_clk,
  input wire logic [15:0] reg_rdata,
  input wire logic int_n_out,
  input wire logic int_n_oe,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_cmd,
  output logic [15:0] reg_wdata,
  output logic int_pin,
  output logic rd_valid,
  output logic [15:0] rd_data
);
  assign int_pin = int_n_oe ? int_n_out : 1'b1; // pull-up when released
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_cmd = 8'h00;
    reg_wdata = 16'h0000;
  end
  always @(posedge sys_clk) begin
    rd_valid <= reg_rd;
    rd_data <= reg_rdata;
  end
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    reg_cmd = c;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] c);
    reg_cmd = c;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    @(negedge sys_clk);
  endtask
endmodule // host_bus_model

/* verif/light_proximity_threshold_irq_tb.sv */
// self-checking bench for the sensor readout block
`timescale 1ns/100ps
`include "light_prox_defines.svh"
module light_proximity_threshold_irq_tb;
  localparam int AMB_CYC = 10;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] amb_raw = 16'h0000;
  logic [15:0] prox_raw = 16'h0000;
  logic sun = 1'b0;
  logic reg_wr, reg_rd, rd_valid, int_pin, emit, amb_smp, prox_smp, int_out, int_oe, hd, ns;
  logic [7:0] reg_cmd;
  logic [15:0] reg_wdata, reg_rdata, rd_data, canc;
  logic [15:0] exp_q[$];
  integer seed = 32'h9210EE1E;
  integer r;
  int err_total = 0;
  int checks = 0;
  int n;
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  light_prox_core #(.AMB_BASE_CYC(AMB_CYC)) u_dut (.sys_clk(sys_clk), .srst(srst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .amb_raw(amb_raw), .prox_raw(prox_raw), .sunlight(sun),
    .emitter_drive_pin(emit), .amb_sample(amb_smp), .prox_sample(prox_smp),
    .int_n_in(int_pin), .int_n_out(int_out), .int_n_oe(int_oe));
  host_bus_model hb (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .int_n_out(int_out),
    .int_n_oe(int_oe), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd),
    .reg_wdata(reg_wdata), .int_pin(int_pin), .rd_valid(rd_valid), .rd_data(rd_data));
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
    checks++;
    if (got !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic rx(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    hb.rd(c);
  endtask
  task automatic ws(input logic p, input int lim);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while ((p ? prox_smp : amb_smp) !== 1'b1 && n < lim);
  endtask
  task automatic give_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (rd_valid === 1'b1 && exp_q.size() > 0) begin
      chk("read word", exp_q.pop_front(), rd_data);
    end
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end
  // ==========
  // main sequence
  initial begin
    repeat (4) @(negedge sys_clk);
    srst = 1'b0;
    rx(`CMD_AMB_CONF, `RST_AMB_CONF);
    rx(`CMD_PROX_CONF12, `RST_PROX_CONF12);
    r = $random(seed);
    hb.wr(`CMD_PROX_THL, r[15:0]);
    rx(`CMD_PROX_THL, r[15:0]);
    rx(8'h09, 16'h0000);
    hb.wr(`CMD_AMB_THH, 16'h8000);
    hb.wr(`CMD_AMB_THL, 16'h0010);
    for (int i = 0; i < 5; i++) begin
      r = $random(seed);
      amb_raw = {4'h4, r[11:0]};
      hd = i inside {1, 2, 4};
      ns = i inside {2, 3, 4};
      hb.wr(`CMD_AMB_CONF, {3'b000, ns, hd, 3'b000, (i == 4) ? 3'b111 : 3'(i), 5'b00010});
      ws(1'b0, 200);
      ws(1'b0, 200);
      chk("amb period", 16'(AMB_CYC << ((i == 4) ? 4 : i)), 16'(n));
      @(negedge sys_clk);
      rx(`CMD_AMB_DATA, amb_raw >> (int'(hd) + int'(ns)));
    end
    hb.wr(`CMD_AMB_CONF, 16'h0002);
    for (int i = 0; i < 2; i++) begin
      amb_raw = i ? 16'h0005 : 16'hF000;
      ws(1'b0, 200);
      repeat (3) @(negedge sys_clk);
      chk("pin low", 16'h0000, {15'h0000, int_pin});
      amb_raw = 16'h2000;
      rx(`CMD_AMB_THH, 16'h8000);
      rx(`CMD_FLAGS, i ? 16'h2000 : 16'h1000);
      chk("pin high", 16'h0001, {15'h0000, int_pin});
    end
    hb.wr(`CMD_AMB_CONF, 16'h000A);
    amb_raw = 16'hF000;
    repeat (3) ws(1'b0, 200);
    // change the input only after the sample edge has taken it
    @(negedge sys_clk);
    amb_raw = 16'h2000;
    ws(1'b0, 200);
    @(negedge sys_clk);
    amb_raw = 16'hF000;
    repeat (3) ws(1'b0, 200);
    repeat (3) @(negedge sys_clk);
    chk("pin early", 16'h0001, {15'h0000, int_pin});
    ws(1'b0, 200);
    repeat (3) @(negedge sys_clk);
    chk("pin late", 16'h0000, {15'h0000, int_pin});
    amb_raw = 16'h2000;
    rx(`CMD_FLAGS, 16'h1000);
    hb.wr(`CMD_AMB_CONF, `RST_AMB_CONF);
    hb.wr(`CMD_PROX_CONF34, 16'h0008);
    hb.wr(`CMD_PROX_THL, 16'h0010);
    hb.wr(`CMD_PROX_THH, 16'h0100);
    hb.wr(`CMD_PROX_CONF12, 16'h0308);
    for (int j = 0; j < 2; j++) begin
      r = $random(seed);
      prox_raw = {6'h01, r[9:0]};
      canc = j ? prox_raw + 16'h0001 : {8'h00, r[23:16]};
      hb.wr(`CMD_PROX_CANC, canc);
      hb.wr(`CMD_PROX_CONF34, 16'h000C);
      ws(1'b1, 2000);
      repeat (3) @(negedge sys_clk);
      rx(`CMD_PROX_DATA, j ? 16'h0000 : prox_raw - canc);
      rx(`CMD_FLAGS, j ? 16'h0100 : 16'h0200);
    end
    ws(1'b1, 1500);
    chk("one shot", 16'h05DC, 16'(n));
    sun = 1'b1;
    @(negedge sys_clk);
    sun = 1'b0;
    chk("pin sun", 16'h0000, {15'h0000, int_pin});
    rx(`CMD_FLAGS, 16'h0400);
    chk("pin clear", 16'h0001, {15'h0000, int_pin});
    // logic output mode: pin follows the close state, not the flags
    hb.wr(`CMD_PROX_CANC, 16'h0000);
    hb.wr(`CMD_PROX_CONF34, 16'h400C);
    ws(1'b1, 2000);
    repeat (3) @(negedge sys_clk);
    rx(`CMD_FLAGS, 16'h0200);
    chk("logic close", 16'h0000, {15'h0000, int_pin});
    hb.wr(`CMD_PROX_CANC, prox_raw + 16'h0001);
    hb.wr(`CMD_PROX_CONF34, 16'h400C);
    ws(1'b1, 2000);
    repeat (3) @(negedge sys_clk);
    chk("logic away", 16'h0001, {15'h0000, int_pin});
    // mid-run reset brings written registers back to defaults
    srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    rx(`CMD_PROX_CONF34, `RST_ZERO);
    rx(`CMD_PROX_CANC, `RST_ZERO);
    chk("pin reset", 16'h0001, {15'h0000, int_pin});
    repeat (4) @(negedge sys_clk);
    give_verdict();
  end
endmodule // light_proximity_threshold_irq_tb
